// >>> logic/sfps_params.svh
`ifndef SFPS_PARAMS_SVH
`define SFPS_PARAMS_SVH

// ***********************************************************
// array geometry
// ***********************************************************
`define SFPS_PART0_BYTES 4096
`define SFPS_PART1_BYTES 128
`define SFPS_PAGE_BYTES 64
`define SFPS_ADDR_DECODE_BITS 12
`define SFPS_ERASED_BYTE 8'hFF

// ***********************************************************
// serial command targets
// ***********************************************************
`define SFPS_TGT_DHR_LAST 4'h3
`define SFPS_TGT_PORT_FLASH_ADDRESS_REG_LAST 4'h7
`define SFPS_TGT_CMD 4'h8
`define SFPS_TGT_MODE 4'h9

// ***********************************************************
// command register values
// ***********************************************************
`define SFPS_CMD_PORT_WRITE 4'h0
`define SFPS_CMD_FLASH_WRITE 4'h1
`define SFPS_CMD_FLASH_READ 4'h3
`define SFPS_CMD_HALT 4'h7
`define SFPS_CMD_RESET 4'hB
`define SFPS_CMD_PAGE_ERASE 4'hD
`define SFPS_CMD_TOTAL_ERASE 4'hE
`define SFPS_CMD_CHANGE_PART 4'hF

// ***********************************************************
// interface mode values
// ***********************************************************
`define SFPS_MODE_FOUR_WIRE 4'h0
`define SFPS_MODE_THREE_WIRE_OE 4'h1

// ***********************************************************
// write power bit in port D
// ***********************************************************
`define SFPS_PWR_PORT 4'hD
`define SFPS_PWR_BIT 12

// ***********************************************************
// timing
// ***********************************************************
`define SFPS_CLK_PERIOD_NS 40
`define SFPS_PROG_TIME_NS 80000
`define SFPS_ERASE_TIME_NS 4200000
`define SFPS_PROG_CYCLES ((`SFPS_PROG_TIME_NS + `SFPS_CLK_PERIOD_NS - 1) / `SFPS_CLK_PERIOD_NS)
`define SFPS_ERASE_CYCLES ((`SFPS_ERASE_TIME_NS + `SFPS_CLK_PERIOD_NS - 1) / `SFPS_CLK_PERIOD_NS)
`define SFPS_CMD_LATENCY 8

`endif

// >>> logic/sfps_pkg.sv
package sfps_pkg;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef struct packed {
      logic [3:0] command_value_nibble;
      logic [3:0] command_target_nibble;
   } sfps_serial_command_byte_t;

   typedef enum logic [1:0] {
      st_idle,
      st_erasing,
      st_programming
   } sfps_state_t;

   typedef struct packed {
      logic flash_busy;
      logic info_partition_sel;
      logic cpu_halted;
      logic flash_write_power_enable;
      logic four_wire_mode;
   } sfps_status_t;

   typedef struct packed {
      logic wr;
      logic [3:0] sel;
      logic [15:0] data;
   } sfps_port_write_t;

endpackage : sfps_pkg

// >>> logic/sfps_serial_link.sv
`timescale 1ns/1ps
`include "sfps_params.svh"

// link-side shifter, runs on the host's serial clock only while a frame is open
module sfps_serial_link
   import sfps_pkg::*;
(
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic rst_n,
   input wire logic serial_data_in,
   input wire logic [15:0] data_holding_reg,
   output sfps_serial_command_byte_t serial_command_byte,
   output logic serial_data_out
);

   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;

   // ***********************************************************
   // input shift, lsb first; the last eight bits of a frame remain
   // ***********************************************************
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 8'h00;
      end else if (!cs_n) begin
         shift_q <= {serial_data_in, shift_q[7:1]};
      end
   end

   assign serial_command_byte = shift_q;

   // ***********************************************************
   // output bit counter; chip select high clears it, so no edge
   // outside a frame is needed
   // ***********************************************************
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q <= 4'h0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // holding register is quiet while a frame is open, so it is read as a static word
   assign serial_data_out = data_holding_reg[~bit_cnt_q];

endmodule : sfps_serial_link

// >>> logic/sfps_sequencer.sv
`timescale 1ns/1ps
`include "sfps_params.svh"

module sfps_sequencer
   import sfps_pkg::*;
#(
   parameter int P0_BYTES = `SFPS_PART0_BYTES,
   parameter int P1_BYTES = `SFPS_PART1_BYTES,
   parameter int PAGE_BYTES = `SFPS_PAGE_BYTES,
   parameter int ERASE_CYCLES = `SFPS_ERASE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_en,
   input wire logic [15:0] cpu_rd_addr,
   output logic [7:0] cpu_rd_data_q,
   output sfps_status_t status_q,
   output sfps_port_write_t port_write_q,
   output logic cmd_refused_q
);

   localparam int A0W = $clog2(P0_BYTES);
   localparam int A1W = $clog2(P1_BYTES);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int PROG_CYCLES = `SFPS_PROG_CYCLES;
   localparam int TMAX = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
   localparam int TW = $clog2(TMAX + 1);

   // ***********************************************************
   // elaboration checks
   // ***********************************************************
   if (P0_BYTES != (1 << A0W) || A0W > `SFPS_ADDR_DECODE_BITS || P0_BYTES < PAGE_BYTES) begin : g_bad_p0
      $error("program partition size unsupported");
   end
   if (P1_BYTES != (1 << A1W) || P1_BYTES < PAGE_BYTES || PAGE_BYTES < 2) begin : g_bad_p1
      $error("information partition or page size unsupported");
   end
   if (ERASE_CYCLES < 1) begin : g_bad_erase
      $error("erase time must be at least one cycle");
   end

   sfps_serial_command_byte_t link_byte;
   sfps_serial_command_byte_t cmd_q;
   logic cs_meta_q, cs_sync_q, cs_prev_q;
   logic cmd_valid_q;
   logic [15:0] data_holding_reg_q;
   logic [15:0] port_flash_address_reg_q;
   logic [7:0] mem0_q [P0_BYTES];
   logic [7:0] mem1_q [P1_BYTES];
   logic halted_q, part1_q, pwr_q, four_wire_q, oe_armed_q, oe_frame_q, oe_q;
   sfps_state_t state_q;
   logic [TW-1:0] timer_q;
   logic link_sdo;

   // ***********************************************************
   // link domain
   // ***********************************************************
   sfps_serial_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .rst_n(rst_n),
      .serial_data_in(serial_data_in),
      .data_holding_reg(data_holding_reg_q),
      .serial_command_byte(link_byte),
      .serial_data_out(link_sdo)
   );

   // ***********************************************************
   // chip select crossing; the byte is stable once the frame closed
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         cs_meta_q <= cs_n;
         cs_sync_q <= cs_meta_q;
         cs_prev_q <= cs_sync_q;
      end
   end

   logic cs_rise, cs_fall;
   assign cs_rise = cs_sync_q && !cs_prev_q;
   assign cs_fall = !cs_sync_q && cs_prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= 8'h00;
         cmd_valid_q <= 1'b0;
      end else begin
         cmd_valid_q <= cs_rise;
         if (cs_rise) begin
            cmd_q <= link_byte;
         end
      end
   end

   // ***********************************************************
   // decode
   // ***********************************************************
   logic [3:0] tgt, val;
   logic is_cmd, flash_idle, prog_ok;
   logic go_total, go_page, go_write, go_read;
   logic [7:0] rd_byte;
   assign tgt = cmd_q.command_target_nibble;
   assign val = cmd_q.command_value_nibble;
   assign is_cmd = cmd_valid_q && tgt == `SFPS_TGT_CMD;
   assign flash_idle = state_q == st_idle;
   assign prog_ok = flash_idle && pwr_q && halted_q;
   assign go_total = is_cmd && val == `SFPS_CMD_TOTAL_ERASE && prog_ok;
   assign go_page = is_cmd && val == `SFPS_CMD_PAGE_ERASE && prog_ok;
   assign go_write = is_cmd && val == `SFPS_CMD_FLASH_WRITE && prog_ok;
   assign go_read = is_cmd && val == `SFPS_CMD_FLASH_READ && flash_idle && halted_q;
   // upper address bits are simply not looked at
   assign rd_byte = part1_q ? mem1_q[port_flash_address_reg_q[A1W-1:0]]
                            : mem0_q[port_flash_address_reg_q[A0W-1:0]];

   logic flash_cmd, refused;
   assign flash_cmd = is_cmd && (val == `SFPS_CMD_TOTAL_ERASE || val == `SFPS_CMD_PAGE_ERASE ||
                                 val == `SFPS_CMD_FLASH_WRITE || val == `SFPS_CMD_FLASH_READ);
   assign refused = flash_cmd && !(go_total || go_page || go_write || go_read);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_refused_q <= 1'b0;
      end else begin
         cmd_refused_q <= refused;
      end
   end

   // ***********************************************************
   // holding and address registers; a nibble write changes only its nibble, a flash read reloads the whole holding register
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_holding_reg_q <= 16'h0000;
      end else if (go_read) begin
         data_holding_reg_q <= {8'h00, rd_byte};
      end else if (cmd_valid_q && tgt <= `SFPS_TGT_DHR_LAST) begin
         data_holding_reg_q[tgt[1:0]*4 +: 4] <= val;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_flash_address_reg_q <= 16'h0000;
      end else if (cmd_valid_q && tgt > `SFPS_TGT_DHR_LAST && tgt <= `SFPS_TGT_PORT_FLASH_ADDRESS_REG_LAST) begin
         port_flash_address_reg_q[tgt[1:0]*4 +: 4] <= val;
      end
   end

   // ***********************************************************
   // cpu control, partition select, write power
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halted_q <= 1'b0;
         part1_q <= 1'b0;
         pwr_q <= 1'b0;
      end else if (is_cmd) begin
         unique case (val)
            `SFPS_CMD_HALT: begin
               halted_q <= 1'b1;
               part1_q <= 1'b0;
            end
            `SFPS_CMD_CHANGE_PART: begin
               if (halted_q) begin
                  part1_q <= 1'b1;
               end
            end
            `SFPS_CMD_RESET: begin
               halted_q <= 1'b0;
               part1_q <= 1'b0;
               pwr_q <= 1'b0;
            end
            `SFPS_CMD_PORT_WRITE: begin
               if (port_flash_address_reg_q[3:0] == `SFPS_PWR_PORT) begin
                  pwr_q <= data_holding_reg_q[`SFPS_PWR_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_write_q <= '0;
      end else begin
         port_write_q.wr <= is_cmd && val == `SFPS_CMD_PORT_WRITE;
         if (is_cmd && val == `SFPS_CMD_PORT_WRITE) begin
            port_write_q.sel <= port_flash_address_reg_q[3:0];
            port_write_q.data <= data_holding_reg_q;
         end
      end
   end

   // ***********************************************************
   // interface mode and data out enable; enable lags the pin by the sync
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         four_wire_q <= 1'b0;
         oe_armed_q <= 1'b0;
         oe_frame_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         if (cmd_valid_q && tgt == `SFPS_TGT_MODE && val == `SFPS_MODE_FOUR_WIRE) begin
            four_wire_q <= 1'b1;
         end else if (cmd_valid_q && tgt == `SFPS_TGT_MODE && val == `SFPS_MODE_THREE_WIRE_OE) begin
            four_wire_q <= 1'b0;
            oe_armed_q <= 1'b1;
         end else if (cs_fall) begin
            oe_armed_q <= 1'b0;
         end
         if (cs_fall) begin
            oe_frame_q <= oe_armed_q;
         end else if (cs_rise) begin
            oe_frame_q <= 1'b0;
         end
         oe_q <= !cs_sync_q && (four_wire_q || oe_frame_q);
      end
   end

   assign serial_data_out = link_sdo;
   assign serial_data_out_en = oe_q;

   // ***********************************************************
   // busy sequencer
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_idle;
         timer_q <= '0;
      end else begin
         unique case (state_q)
            st_idle: begin
               if (go_total || go_page) begin
                  state_q <= st_erasing;
                  timer_q <= TW'(ERASE_CYCLES - 1);
               end else if (go_write) begin
                  state_q <= st_programming;
                  timer_q <= TW'(PROG_CYCLES - 1);
               end
            end
            st_erasing, st_programming: begin
               if (timer_q == '0) begin
                  state_q <= st_idle;
               end else begin
                  timer_q <= timer_q - TW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= '0;
      end else begin
         status_q.flash_busy <= !flash_idle || go_total || go_page || go_write;
         status_q.info_partition_sel <= part1_q;
         status_q.cpu_halted <= halted_q;
         status_q.flash_write_power_enable <= pwr_q;
         status_q.four_wire_mode <= four_wire_q;
      end
   end

   // ***********************************************************
   // arrays; nonvolatile, so no reset
   // ***********************************************************
   always_ff @(posedge clk) begin
      for (int i = 0; i < P0_BYTES; i++) begin
         if (!part1_q && (go_total || (go_page && (i >> PW) == int'(port_flash_address_reg_q[A0W-1:PW])))) begin
            mem0_q[i] <= `SFPS_ERASED_BYTE;
         end
      end
      if (!part1_q && go_write) begin
         mem0_q[port_flash_address_reg_q[A0W-1:0]] <=
            mem0_q[port_flash_address_reg_q[A0W-1:0]] & data_holding_reg_q[7:0];
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < P1_BYTES; i++) begin
         if (part1_q && (go_total || (go_page && (i >> PW) == int'(port_flash_address_reg_q[A1W-1:PW])))) begin
            mem1_q[i] <= `SFPS_ERASED_BYTE;
         end
      end
      if (part1_q && go_write) begin
         mem1_q[port_flash_address_reg_q[A1W-1:0]] <=
            mem1_q[port_flash_address_reg_q[A1W-1:0]] & data_holding_reg_q[7:0];
      end
   end

   // cpu side is read only and sees the program partition alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rd_data_q <= 8'h00;
      end else begin
         cpu_rd_data_q <= mem0_q[cpu_rd_addr[A0W-1:0]];
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   cmd_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cs_sync_q) |-> ##[1:8] cmd_valid_q)
      else $error("command not taken within eight clocks");

   busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q != st_idle && is_cmd && val == `SFPS_CMD_FLASH_WRITE) |=> cmd_refused_q && status_q.flash_busy)
      else $error("flash command accepted while busy");

   power_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(status_q.flash_busy) |-> status_q.flash_write_power_enable && status_q.cpu_halted)
      else $error("flash operation started without power or halt");

   prog_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
      go_write |=> (state_q == st_programming) [*8])
      else $error("program busy ended early");

   halt_part_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_cmd && val == `SFPS_CMD_HALT) |=> halted_q && !part1_q ##1 !status_q.info_partition_sel)
      else $error("halt did not select program partition");

   read_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
      go_read |=> data_holding_reg_q == {8'h00, $past(rd_byte)})
      else $error("read did not copy byte to holding register");

   reset_power_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_cmd && val == `SFPS_CMD_RESET) |=> !pwr_q ##1 !status_q.flash_write_power_enable)
      else $error("reset command left write power set");

   addr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cmd_valid_q |=> $stable(port_flash_address_reg_q))
      else $error("address register changed without a command");

   page_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
      (go_page && !part1_q) |=> mem0_q[{$past(port_flash_address_reg_q[A0W-1:PW]), PW'(0)}] == `SFPS_ERASED_BYTE)
      else $error("page erase missed first byte of page");

   four_wire_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
      (four_wire_q && !cs_sync_q) |=> serial_data_out_en)
      else $error("four-wire mode did not drive data out");

endmodule : sfps_sequencer

// >>> testbench/sfps_host.sv
`timescale 1ns/1ps

// calibration host: serial clock runs only inside a frame, 32 ns period
module sfps_host (
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // ***********************************************************
   // one frame: n bits out lsb first, data out captured msb first
   // ***********************************************************
   task automatic frame(input logic [15:0] din, input int n, output logic [15:0] dout);
      dout = 16'h0000;
      #7;
      cs_n = 1'b0;
      // data out lags chip select by a few core clocks
      #150;
      for (int i = 0; i < n; i++) begin
         sdi = din[i];
         #16 sclk = 1'b1;
         dout = {dout[14:0], sdo};
         #16 sclk = 1'b0;
      end
      // released line must not keep showing the last bit
      sdi = ~sdi;
      #16 cs_n = 1'b1;
      // chip select stays high well over four core clocks
      #200;
   endtask : frame
endmodule : sfps_host

// >>> testbench/tb.sv
`timescale 1ns/1ps

module tb;
   import sfps_pkg::*;
   localparam int ERASE_CYC = 20;
   logic clk;
   logic rst_n;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic sdo_en;
   logic [15:0] cpu_rd_addr;
   logic [7:0] cpu_rd_data_q;
   sfps_status_t status_q;
   sfps_port_write_t port_write_q;
   sfps_port_write_t last_pw;
   logic cmd_refused_q;
   int n_fail;
   int checks;
   int n_refused;
   int cycles;
   int n_oe;
   int rd_oe;
   logic [15:0] rd;
   logic [11:0] aa [3];
   logic [7:0] dd [3];

   always #20 clk = ~clk;

   sfps_sequencer #(.ERASE_CYCLES(ERASE_CYC)) i_sfps_sequencer (.clk(clk), .rst_n(rst_n), .sclk(sclk),
      .cs_n(cs_n), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_en(sdo_en),
      .cpu_rd_addr(cpu_rd_addr), .cpu_rd_data_q(cpu_rd_data_q), .status_q(status_q),
      .port_write_q(port_write_q), .cmd_refused_q(cmd_refused_q));
   sfps_host i_sfps_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cmd_refused_q === 1'b1) n_refused <= n_refused + 1;
      if (cs_n === 1'b0 && sdo_en === 1'b1) n_oe <= n_oe + 1;
      if (port_write_q.wr === 1'b1) last_pw <= port_write_q;
      if (cycles > 60000) begin
         n_fail++;
         wrap_up();
      end
   end

   function automatic logic [15:0] exp_read(input logic [7:0] old, input logic [7:0] d);
      // programming only clears bits, readout lands in the low byte
      return {8'h00, old & d};
   endfunction : exp_read

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic send(input logic [7:0] b);
      logic [15:0] unused;
      i_sfps_host.frame({8'h00, b}, 8, unused);
      repeat (12) @(posedge clk);
   endtask : send

   task automatic put(input logic [3:0] base, input logic [15:0] v);
      for (int i = 0; i < 4; i++) send({v[4*i +: 4], base + 4'(i)});
   endtask : put

   task automatic wait_idle();
      repeat (3000) begin
         @(negedge clk);
         if (status_q.flash_busy === 1'b0) break;
      end
   endtask : wait_idle

   task automatic rd_flash(input logic [15:0] addr, output logic [15:0] v);
      int oe0;
      put(4'h4, addr);
      send(8'h38);
      oe0 = n_oe;
      // trailing byte of the read frame re-selects four-wire mode, harmless
      i_sfps_host.frame(16'h0909, 16, v);
      repeat (12) @(posedge clk);
      chk("oe_four", 16'h0001, 16'(n_oe > oe0));
   endtask : rd_flash

   task automatic set_power(input logic [15:0] dval);
      logic [15:0] vals [3];
      vals = '{dval, 16'h0031, 16'h8000};
      for (int i = 0; i < 3; i++) begin
         put(4'h0, vals[i]);
         send({4'hD + 4'(i), 4'h4});
         send(8'h08);
      end
   endtask : set_power

   task automatic prog(input logic [15:0] addr, input logic [7:0] d);
      put(4'h4, addr);
      put(4'h0, {8'h00, d});
      send(8'h18);
      chk("busy", 16'h0001, 16'(status_q.flash_busy));
      wait_idle();
   endtask : prog

   task automatic wrap_up();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cpu_rd_addr = 16'h0000;
      n_fail = 0;
      checks = 0;
      n_refused = 0;
      n_oe = 0;
      cycles = 0;
      void'($urandom(13));
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (4) @(posedge clk);
      chk("status", 16'h0000, 16'(status_q));
      send(8'h09);
      chk("four_wire", 16'h0001, 16'(status_q.four_wire_mode));
      send(8'h78);
      send(8'hE8);
      chk("refused", 16'h0001, 16'(n_refused));
      set_power(16'h1000);
      chk("power", 16'h0001, 16'(status_q.flash_write_power_enable));
      chk("port_f", 16'h8000, last_pw.data);
      $display("test setup done");
      send(8'hE8);
      wait_idle();
      for (int k = 0; k < 3; k++) begin
         aa[k] = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : {1'b0, 10'($urandom), 1'b1};
         dd[k] = 8'($urandom);
         rd_flash({4'h0, aa[k]}, rd);
         chk("erased", exp_read(8'hFF, 8'hFF), rd);
         prog({4'($urandom), aa[k]}, dd[k]);
         rd_flash({4'h0, aa[k]}, rd);
         chk("programmed", exp_read(8'hFF, dd[k]), rd);
      end
      // three-wire: enable frame, then one driven read frame, then released again
      send(8'h19);
      rd_oe = n_oe;
      i_sfps_host.frame(16'h0A0A, 16, rd);
      repeat (12) @(posedge clk);
      chk("three_wire", exp_read(8'hFF, dd[2]), rd);
      chk("oe_three", 16'h0001, 16'(n_oe > rd_oe));
      rd_oe = n_oe;
      send(8'h0A);
      chk("oe_released", 16'h0000, 16'(n_oe > rd_oe));
      send(8'h09);
      $display("test program done");
      send(8'h78);
      send(8'hF8);
      chk("info_sel", 16'h0001, 16'(status_q.info_partition_sel));
      send(8'hE8);
      wait_idle();
      prog(16'h0005, 8'h3C);
      prog(16'h007F, 8'hA5);
      // second write lands while the first is still busy
      send(8'h18);
      send(8'h18);
      chk("refused", 16'h0002, 16'(n_refused));
      wait_idle();
      // page address keeps bits 5 and 4 at zero
      put(4'h4, 16'h0040);
      send(8'hD8);
      wait_idle();
      rd_flash(16'h0005, rd);
      chk("page0_kept", exp_read(8'hFF, 8'h3C), rd);
      rd_flash(16'h007F, rd);
      chk("page1_erased", 16'h00FF, rd);
      $display("test info done");
      send(8'h78);
      chk("info_sel", 16'h0000, 16'(status_q.info_partition_sel));
      rd_flash({4'h0, aa[2]}, rd);
      chk("other_part", exp_read(8'hFF, dd[2]), rd);
      put(4'h4, 16'h0FC0);
      send(8'hD8);
      wait_idle();
      rd_flash(16'h0FFF, rd);
      chk("page_erased", 16'h00FF, rd);
      rd_flash({4'h0, aa[0]}, rd);
      chk("page_kept", exp_read(8'hFF, dd[0]), rd);
      dd[1] = 8'hFF;
      set_power(16'h0000);
      chk("power", 16'h0000, 16'(status_q.flash_write_power_enable));
      send(8'h18);
      chk("refused", 16'h0003, 16'(n_refused));
      set_power(16'h1000);
      send(8'hB8);
      chk("power", 16'h0000, 16'(status_q.flash_write_power_enable));
      chk("halted", 16'h0000, 16'(status_q.cpu_halted));
      // power on but cpu running: erase must be refused
      set_power(16'h1000);
      send(8'hE8);
      chk("refused", 16'h0004, 16'(n_refused));
      for (int k = 0; k < 3; k++) begin
         @(negedge clk) cpu_rd_addr = {4'($urandom), aa[k]};
         repeat (2) @(negedge clk);
         chk("cpu_read", exp_read(8'hFF, dd[k]), {8'h00, cpu_rd_data_q});
      end
      $display("test cpu done");
      wrap_up();
   end
endmodule : tb
